// ---- common/scr_pkg.sv ----
// Shared constants and types for the storage core register block.
package scr_pkg;

    // Register index space of the core and register indices (wishbone address bits 7:2).
    localparam int unsigned REG_SPACE = 32;
    localparam logic [7:0] IDX_GP0 = 8'h00;
    localparam logic [7:0] IDX_DP0 = 8'h04;
    localparam logic [7:0] IDX_FLAGS = 8'h08;
    localparam logic [7:0] IDX_PC = 8'h09;
    localparam logic [7:0] IDX_HCTRL = 8'h0A;
    localparam logic [7:0] IDX_HSTAT = 8'h0B;
    localparam logic [7:0] IDX_PCHI = 8'h0C;
    localparam logic [7:0] IDX_PCLO = 8'h0D;

    // Widths of the programmer-visible state.
    localparam int unsigned GP_W = 16;
    localparam int unsigned DP_W = 12;
    localparam int unsigned PC_W = 11;
    localparam int unsigned PC_HI_W = 3;
    localparam int unsigned PC_LO_W = 8;
    localparam int unsigned FLAGS_W = 5;

    // Memory sizes addressed by the core, in words.
    localparam int unsigned PROG_WORDS = 1024;
    localparam int unsigned DATA_WORDS = 2560;

    // Core flag bit positions and reset value.
    localparam int unsigned FL_CARRY = 0;
    localparam int unsigned FL_ZERO = 1;
    localparam int unsigned FL_COND = 2;
    localparam int unsigned FL_STEP = 3;
    localparam int unsigned FL_WPOL = 4;
    localparam logic [15:0] FLAGS_RST = 16'h0018;

    // Host control bit positions.
    localparam int unsigned HC_SOFT = 0;
    localparam int unsigned HC_PCF = 1;
    localparam int unsigned HC_GO = 3;
    localparam int unsigned HC_HIE = 4;
    localparam int unsigned HC_NIE = 5;
    localparam logic [7:0] HCTRL_RST = 8'h01;

    // Host status bit positions.
    localparam int unsigned HS_HCLR = 0;
    localparam int unsigned HS_NCLR = 1;
    localparam int unsigned HS_HALT = 4;
    localparam int unsigned HS_NOTE = 5;

    // Core instruction events driven by the execution unit.
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_WPOL_HI = 5'h01,
        OP_WPOL_LO = 5'h02,
        OP_STEP_UP = 5'h03,
        OP_STEP_DN = 5'h04,
        OP_SET_CMP = 5'h05,
        OP_CLR_CMP = 5'h06,
        OP_SET_ZERO = 5'h07,
        OP_CLR_ZERO = 5'h08,
        OP_SET_CARRY = 5'h09,
        OP_CLR_CARRY = 5'h0A,
        OP_STOP = 5'h0B,
        OP_NOTIFY = 5'h0C
    } scr_op_t;

    // One retired instruction as reported by the execution unit.
    typedef struct packed {
        logic valid;
        scr_op_t op;
        logic alu_upd;
        logic alu_zero;
        logic carry_upd;
        logic carry;
        logic cmp_upd;
        logic cmp;
        logic [PC_W-1:0] next_pc;
        logic call;
        logic ret;
        logic [1:0] gp_wr;
        logic [GP_W-1:0] gp_data;
        logic gp_we;
        logic [1:0] dp_sel;
        logic dp_load;
    } scr_retire_t;

endpackage : scr_pkg

// ---- logic/scr_call_stack.sv ----
// Call frame stack saving core state across subroutine calls.
module scr_call_stack
    import scr_pkg::*;
#(
    parameter int unsigned DEPTH = 4,
    parameter int unsigned FRAME_W = 2 * GP_W + DP_W + PC_W + FLAGS_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [FRAME_W-1:0] frame_i,
    output logic [FRAME_W-1:0] frame_o
);

    localparam int unsigned PTR_W = $clog2(DEPTH);

    // Refuse at elaboration a depth that the wrapping pointer cannot serve.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("call stack depth must be a power of two");
    end

    logic [FRAME_W-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] ptr_q;

    // Pointer moves up on a push and down on a pop; wraps when overrun.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ptr_q <= '0;
        else if (push_i)
            ptr_q <= ptr_q + 1'b1;
        else if (pop_i)
            ptr_q <= ptr_q - 1'b1;
    end

    // Frame storage written at the current top.
    always_ff @(posedge clk_i)
    begin
        if (push_i)
            mem_q[ptr_q] <= frame_i;
    end

    assign frame_o = mem_q[ptr_q - 1'b1];

endmodule : scr_call_stack

// ---- logic/scr_core_regs.sv ----
// Storage core register file, flags and host control over wishbone.
// What this block does
// [RULE1] Core addresses 1K program, 2.5K data, 32 registers.
// [RULE2] Four 16-bit general registers, reset zero.
// [RULE3] Four 12-bit data pointers supply data addresses.
// [RULE4] 11-bit program counter advances per instruction.
// [RULE5] Call saves state; return restores it.
// [RULE6] Flags reset with polarity and step-up set.
// [RULE7] Bit 4 selects wait polarity.
// [RULE8] Bit 3 selects pointer step direction.
// [RULE9] Bit 2 holds last comparison outcome.
// [RULE10] Bit 1 marks zero ALU result.
// [RULE11] Bit 0 captures carry, borrow and shifts.
// [RULE12] Soft reset holds whole core in reset.
// [RULE13] Program counter force loads preset value.
// [RULE14] Go resumes a core halted by stop.
// [RULE15] Stop instruction halts and sets halt flag.
// [RULE16] Halt flag with enable raises interrupt.
// [RULE17] Notify instruction sets flag, core runs on.
// [RULE18] Notify interrupt has its own enable.
// [RULE19] Go self-clears, reads zero, pulses once.
// [RULE20] Flags clear by force, soft reset, clear bits.
// [RULE21] Preset loads into counter on soft reset or force; hard reset loads zero instead.
// [RULE22] Reserved flag bits read zero, ignore writes.
module scr_core_regs
    import scr_pkg::*;
#(
    parameter int unsigned STACK_DEPTH = 4
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire scr_pkg::scr_retire_t retire_i,
    output logic core_rst_o,
    output logic run_o,
    output logic go_pulse_o,
    output logic irq_o,
    output logic [PC_W-1:0] pc_o,
    output logic [DP_W-1:0] data_addr_o,
    output logic wait_pol_o,
    output logic step_up_o
);
    import scr_pkg::*;

    localparam int unsigned FRAME_W = 2 * GP_W + DP_W + PC_W + FLAGS_W;
    localparam logic [31:0] ADDR_SPACE = 32'(REG_SPACE);
    localparam logic [31:0] PROG_LIMIT = 32'(PROG_WORDS);
    localparam logic [31:0] DATA_LIMIT = 32'(DATA_WORDS);

    // Elaboration checks on the stack depth and the counter widths.
    if (STACK_DEPTH < 2)
    begin : g_bad_stack
        $error("stack depth too small");
    end
    if (PROG_LIMIT < (32'd1 << PC_W) / 2 || DATA_LIMIT > (32'd1 << DP_W))
    begin : g_bad_sizes
        $error("memory sizes do not fit counter widths"); // RULE1
    end

    logic [GP_W-1:0] gp_q [4];
    logic [DP_W-1:0] dp_q [4];
    logic [FLAGS_W-1:0] flags_q;
    logic [PC_W-1:0] pc_q;
    logic [7:0] hctrl_q;
    logic halt_q;
    logic notify_q;
    logic run_q;
    logic [PC_HI_W-1:0] pchi_q;
    logic [PC_LO_W-1:0] pclo_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic go_q;
    logic irq_q;
    logic [FRAME_W-1:0] frame_in;
    logic [FRAME_W-1:0] frame_out;

    // Bus write strobe: one access per request, gated by the ack.
    logic acc;
    logic wr;
    logic [7:0] idx;
    assign acc = cyc_i && stb_i && !ack_q;
    assign wr = acc && we_i && sel_i[0];
    assign idx = {2'b00, adr_i[7:2]};

    // Hold and force states from the host control register.
    logic soft_rst;
    logic pc_force;
    logic core_hold;
    logic [PC_W-1:0] preset;
    assign soft_rst = hctrl_q[HC_SOFT];
    assign pc_force = hctrl_q[HC_PCF];
    assign core_hold = rst_i || soft_rst;
    assign preset = {pchi_q, pclo_q};

    // Register index match for core registers.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    logic ret_ev;
    logic call_ev;
    assign ret_ev = retire_i.valid && run_q && retire_i.ret;
    assign call_ev = retire_i.valid && run_q && retire_i.call;

    // General registers: bus write or retire write; return restores 0 and 1.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_gp
            always_ff @(posedge clk_i)
            begin
                if (core_hold)
                    gp_q[g] <= '0; // RULE2 RULE12
                else if (ret_ev && g < 2)
                    gp_q[g] <= frame_out[FRAME_W-1-g*GP_W -: GP_W]; // RULE5
                else if (wr && hit(idx, IDX_GP0 + 8'(g)))
                    gp_q[g] <= dat_i[GP_W-1:0]; // RULE2
                else if (retire_i.valid && run_q && retire_i.gp_we
                         && retire_i.gp_wr == 2'(g))
                    gp_q[g] <= retire_i.gp_data;
            end
        end
    endgenerate

    // Data pointers: bus write, post step on loads, return restores 0.
    generate
        for (g = 0; g < 4; g++)
        begin : gen_dp
            always_ff @(posedge clk_i)
            begin
                if (core_hold)
                    dp_q[g] <= '0; // RULE3
                else if (ret_ev && g == 0)
                    dp_q[g] <= frame_out[FLAGS_W+PC_W +: DP_W]; // RULE5
                else if (wr && hit(idx, IDX_DP0 + 8'(g)))
                    dp_q[g] <= dat_i[DP_W-1:0]; // RULE3
                else if (retire_i.valid && run_q && retire_i.dp_load
                         && retire_i.dp_sel == 2'(g))
                    dp_q[g] <= flags_q[FL_STEP] ? dp_q[g] + 1'b1
                                                : dp_q[g] - 1'b1; // RULE8
            end
        end
    endgenerate

    // Core flags: instructions, ALU updates, bus write and return restore.
    always_ff @(posedge clk_i)
    begin
        if (core_hold)
            flags_q <= FLAGS_RST[FLAGS_W-1:0]; // RULE6
        else if (ret_ev)
            flags_q <= frame_out[FLAGS_W-1:0]; // RULE5
        else if (wr && hit(idx, IDX_FLAGS))
            flags_q <= dat_i[FLAGS_W-1:0]; // RULE22
        else if (retire_i.valid && run_q)
        begin
            if (retire_i.op == OP_WPOL_HI)
                flags_q[FL_WPOL] <= 1'b1; // RULE7
            if (retire_i.op == OP_WPOL_LO)
                flags_q[FL_WPOL] <= 1'b0; // RULE7
            if (retire_i.op == OP_STEP_UP)
                flags_q[FL_STEP] <= 1'b1; // RULE8
            if (retire_i.op == OP_STEP_DN)
                flags_q[FL_STEP] <= 1'b0; // RULE8
            if (retire_i.op == OP_SET_CMP)
                flags_q[FL_COND] <= 1'b1; // RULE9
            else if (retire_i.op == OP_CLR_CMP)
                flags_q[FL_COND] <= 1'b0; // RULE9
            else if (retire_i.cmp_upd)
                flags_q[FL_COND] <= retire_i.cmp; // RULE9
            if (retire_i.op == OP_SET_ZERO)
                flags_q[FL_ZERO] <= 1'b1; // RULE10
            else if (retire_i.op == OP_CLR_ZERO)
                flags_q[FL_ZERO] <= 1'b0; // RULE10
            else if (retire_i.alu_upd)
                flags_q[FL_ZERO] <= retire_i.alu_zero; // RULE10
            if (retire_i.op == OP_SET_CARRY)
                flags_q[FL_CARRY] <= 1'b1; // RULE11
            else if (retire_i.op == OP_CLR_CARRY)
                flags_q[FL_CARRY] <= 1'b0; // RULE11
            else if (retire_i.carry_upd)
                flags_q[FL_CARRY] <= retire_i.carry; // RULE11
        end
    end

    // Program counter: zero on hard reset, preset on soft reset or force, else follows retirement.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pc_q <= '0;
        else if (soft_rst || pc_force)
            pc_q <= preset; // RULE13 RULE21
        else if (ret_ev)
            pc_q <= frame_out[FLAGS_W +: PC_W]; // RULE5
        else if (retire_i.valid && run_q)
            pc_q <= retire_i.next_pc; // RULE4
    end

    // Frame pushed on a call: gp0, gp1, pointer 0, return address, flags.
    assign frame_in = {gp_q[0], gp_q[1], dp_q[0], retire_i.next_pc, flags_q};

    scr_call_stack #(
        .DEPTH(STACK_DEPTH),
        .FRAME_W(FRAME_W)
    ) u_stack (
        .clk_i(clk_i),
        .rst_i(core_hold),
        .push_i(call_ev), // RULE5
        .pop_i(ret_ev),
        .frame_i(frame_in),
        .frame_o(frame_out)
    );

    // Host control register; go is a self-clearing strobe.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            hctrl_q <= HCTRL_RST;
        else if (wr && hit(idx, IDX_HCTRL))
            hctrl_q <= {2'b00, dat_i[5:4], 1'b0, 1'b0, dat_i[1:0]}; // RULE19
    end

    // Launch pulse lasts one cycle per write of one to go.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            go_q <= 1'b0;
        else
            go_q <= wr && hit(idx, IDX_HCTRL) && dat_i[HC_GO]; // RULE19
    end

    // Preset registers for the program counter.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pchi_q <= '0;
            pclo_q <= '0;
        end
        else if (wr && hit(idx, IDX_PCHI))
            pchi_q <= dat_i[PC_HI_W-1:0]; // RULE21
        else if (wr && hit(idx, IDX_PCLO))
            pclo_q <= dat_i[PC_LO_W-1:0]; // RULE21
    end

    logic stop_ev;
    logic note_ev;
    assign stop_ev = retire_i.valid && run_q && retire_i.op == OP_STOP;
    assign note_ev = retire_i.valid && run_q && retire_i.op == OP_NOTIFY;

    // Halt flag: set by stop wins over a host clear; resets clear it.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_rst || pc_force)
            halt_q <= 1'b0; // RULE20
        else if (stop_ev)
            halt_q <= 1'b1; // RULE15
        else if (wr && hit(idx, IDX_HSTAT) && dat_i[HS_HCLR])
            halt_q <= 1'b0; // RULE20
    end

    // Notify flag, same policy with its own clear bit.
    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_rst || pc_force)
            notify_q <= 1'b0; // RULE20
        else if (note_ev)
            notify_q <= 1'b1; // RULE17
        else if (wr && hit(idx, IDX_HSTAT) && dat_i[HS_NCLR])
            notify_q <= 1'b0; // RULE20
    end

    // Run state: stops on stop, resumes on go, idle under any hold.
    always_ff @(posedge clk_i)
    begin
        if (core_hold || pc_force)
            run_q <= 1'b0; // RULE12
        else if (stop_ev)
            run_q <= 1'b0; // RULE15
        else if (go_q || (!run_q && !halt_q))
            run_q <= 1'b1; // RULE14
    end

    // Interrupt request from enabled flags, registered.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_q <= 1'b0;
        else
            irq_q <= (halt_q && hctrl_q[HC_HIE])
                     || (notify_q && hctrl_q[HC_NIE]); // RULE16 RULE18
    end

    // Read mux with one cycle ack; unmapped indices read zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end
        else
        begin
            ack_q <= acc;
            dat_q <= '0;
            if (acc && !we_i && 32'(idx) < ADDR_SPACE)
            begin
                if (idx < IDX_DP0)
                    dat_q <= 32'(gp_q[idx[1:0]]);
                else if (idx < IDX_FLAGS)
                    dat_q <= 32'(dp_q[idx[1:0]]);
                else if (hit(idx, IDX_FLAGS))
                    dat_q <= 32'(flags_q); // RULE22
                else if (hit(idx, IDX_PC))
                    dat_q <= 32'(pc_q);
                else if (hit(idx, IDX_HCTRL))
                    dat_q <= 32'(hctrl_q); // RULE19
                else if (hit(idx, IDX_HSTAT))
                    dat_q <= 32'({notify_q, halt_q, 4'h0}); // RULE20
                else if (hit(idx, IDX_PCHI))
                    dat_q <= 32'(pchi_q);
                else if (hit(idx, IDX_PCLO))
                    dat_q <= 32'(pclo_q);
            end
        end
    end

    // Registered view of core state for the execution unit.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            core_rst_o <= 1'b1;
            data_addr_o <= '0;
            wait_pol_o <= 1'b1;
            step_up_o <= 1'b1;
        end
        else
        begin
            core_rst_o <= core_hold; // RULE12
            data_addr_o <= dp_q[retire_i.dp_sel]; // RULE3
            wait_pol_o <= flags_q[FL_WPOL]; // RULE7
            step_up_o <= flags_q[FL_STEP]; // RULE8
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign run_o = run_q;
    assign go_pulse_o = go_q;
    assign irq_o = irq_q;
    assign pc_o = pc_q;

    a_halt_sets: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_ev && !soft_rst && !pc_force |=> halt_q && !run_q)
        else $error("stop did not halt"); // RULE15
    a_irq_halt: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_q && hctrl_q[HC_HIE] |=> irq_q)
        else $error("halt irq missing"); // RULE16
    a_irq_note: assert property (@(posedge clk_i) disable iff (rst_i)
        !halt_q && !notify_q |=> !irq_q)
        else $error("spurious irq"); // RULE18
    a_go_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        go_q |=> !go_q && !hctrl_q[HC_GO])
        else $error("go not one cycle"); // RULE19
    a_pc_force: assert property (@(posedge clk_i) disable iff (rst_i)
        pc_force |=> pc_q == $past(preset))
        else $error("pc not forced"); // RULE13
    a_soft_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_rst |=> flags_q == FLAGS_RST[FLAGS_W-1:0] && gp_q[0] == '0)
        else $error("soft reset not held"); // RULE12
    a_note_runs: assert property (@(posedge clk_i) disable iff (rst_i)
        note_ev && !soft_rst && !pc_force |=> notify_q && run_q)
        else $error("notify stopped core"); // RULE17
    a_go_resume: assert property (@(posedge clk_i) disable iff (rst_i)
        go_q && !core_hold && !pc_force && !stop_ev |=> run_q)
        else $error("go did not resume"); // RULE14

endmodule : scr_core_regs

// ---- testbench/scr_exec_model.sv ----
// Execution unit stand-in that retires instructions into the register block.
module scr_exec_model
(
    input wire logic clk_i,
    output scr_pkg::scr_retire_t retire_o
);
    import scr_pkg::*;

    // Start idle so the block sees no instruction before the first request.
    initial retire_o = '0;

    // Between instructions the fields carry junk with valid low, so the
    // block cannot get away with acting on stale payload.
    task automatic idle();
        logic [63:0] junk;
        scr_retire_t r;
        junk = {$urandom, $urandom};
        r = scr_retire_t'(junk[$bits(scr_retire_t)-1:0]);
        r.valid = 1'b0;
        retire_o <= r;
    endtask : idle

    // Retire one instruction for exactly one cycle, then fall idle.
    task automatic issue(input scr_retire_t r);
        @(posedge clk_i);
        retire_o <= r;
        @(posedge clk_i);
        idle();
    endtask : issue
endmodule : scr_exec_model

// ---- testbench/tb_scr_core_regs.sv ----
// Self-checking bench for the storage core register block.
module tb_scr_core_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import scr_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic [31:0] rd;
    logic ack_o, core_rst_o, run_o, go_pulse_o, irq_o, wait_pol_o, step_up_o;
    logic [PC_W-1:0] pc_o;
    logic [DP_W-1:0] data_addr_o;
    scr_retire_t retire_i;
    scr_retire_t t;
    int num_errors = 0;
    int n_checks = 0;
    int cyc_n = 0;
    int go_n = 0;
    int gp[8];
    int fl, i, v;

    scr_core_regs #(.STACK_DEPTH(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .retire_i(retire_i), .core_rst_o(core_rst_o), .run_o(run_o),
        .go_pulse_o(go_pulse_o), .irq_o(irq_o), .pc_o(pc_o),
        .data_addr_o(data_addr_o), .wait_pol_o(wait_pol_o),
        .step_up_o(step_up_o));

    scr_exec_model u_exec (.clk_i(clk_i), .retire_o(retire_i));

    // Clock at 10 MHz.
    always #50 clk_i = ~clk_i;

    // Count launch pulses and cut a hang short.
    always @(posedge clk_i)
    begin
        cyc_n <= cyc_n + 1;
        go_n <= go_n + int'(go_pulse_o === 1'b1);
        if (cyc_n == 20000)
        begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (num_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %0t pin level %b expected %b", $time, got, exp);
        end
    endtask : chk_pin

    // One classic cycle; request held until ack is sampled high.
    task automatic wb(input logic [7:0] idx, input logic w,
                      input logic [3:0] s, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx[5:0], 2'b00};
        sel_i <= s;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        wb(idx, 1'b1, 4'hF, d);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        wb(idx, 1'b0, 4'hF, 32'h0000_0000);
        chk_reg(rd, exp);
    endtask : rdc

    function automatic scr_retire_t mk(input scr_op_t op);
        scr_retire_t r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        return r;
    endfunction : mk

    // Flag instructions come in set/clear pairs from bit 4 down to bit 0.
    function automatic int op_fx(input int f, input int op);
        int b;
        b = 4 - (op - 1) / 2;
        return (op % 2) ? (f | (1 << b)) : (f & ~(1 << b));
    endfunction : op_fx

    // Main sequence.
    initial
    begin
        v = $urandom(97512);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(IDX_HCTRL, 32'h0000_0001);
        rdc(IDX_FLAGS, 32'h0000_0018);
        rdc(IDX_HSTAT, 32'h0000_0000);
        for (i = 0; i < 8; i++)
            rdc(i[7:0], 32'h0000_0000);
        @(negedge clk_i);
        chk_pin(core_rst_o, 1'b1);
        chk_pin(run_o, 1'b0);
        wr(IDX_PCHI, 32'h0000_00FD);
        wr(IDX_PCLO, 32'h0000_00A3);
        rdc(IDX_PCHI, 32'h0000_0005);
        rdc(IDX_PCLO, 32'h0000_00A3);
        wr(IDX_HCTRL, 32'h0000_0000);
        @(negedge clk_i);
        chk_pin(core_rst_o, 1'b0);
        chk_reg(32'(pc_o), 32'h0000_05A3);
        // Random register contents, masked to each width.
        for (i = 0; i < 8; i++)
        begin
            v = $urandom;
            wr(i[7:0], v);
            gp[i] = v & (i < 4 ? 32'h0000_FFFF : 32'h0000_0FFF);
        end
        for (i = 0; i < 8; i++)
            rdc(i[7:0], gp[i]);
        wb(8'h00, 1'b1, 4'hE, 32'h0000_1234);
        rdc(8'h00, gp[0]);
        wr(8'h1F, 32'h0000_FFFF);
        rdc(8'h1F, 32'h0000_0000);
        wr(IDX_PC, 32'h0000_0011);
        rdc(IDX_PC, 32'h0000_05A3);
        wr(IDX_FLAGS, 32'h0000_FFFF);
        rdc(IDX_FLAGS, 32'h0000_001F);
        wr(IDX_FLAGS, 32'h0000_0000);
        fl = 0;
        // Every flag instruction once, then a random mix.
        for (i = 0; i < 20; i++)
        begin
            v = (i < 10) ? i + 1 : 1 + $urandom % 10;
            u_exec.issue(mk(scr_op_t'(v)));
            fl = op_fx(fl, v);
            rdc(IDX_FLAGS, fl);
            chk_pin(wait_pol_o, fl[4]);
            chk_pin(step_up_o, fl[3]);
        end
        // ALU outcome flags and program counter advance in one instruction.
        t = mk(OP_NONE);
        t.alu_upd = 1'b1;
        t.alu_zero = 1'b1;
        t.carry_upd = 1'b1;
        t.carry = ~fl[0];
        t.cmp_upd = 1'b1;
        t.cmp = ~fl[2];
        t.next_pc = 11'h123;
        u_exec.issue(t);
        fl = (fl ^ 5) | 2;
        rdc(IDX_FLAGS, fl);
        rdc(IDX_PC, 32'h0000_0123);
        // A load steps pointer 2 and the same instruction writes gp 3.
        t = mk(OP_NONE);
        t.dp_load = 1'b1;
        t.dp_sel = 2'd2;
        t.gp_we = 1'b1;
        t.gp_wr = 2'd3;
        t.gp_data = 16'($urandom);
        u_exec.issue(t);
        gp[3] = t.gp_data;
        gp[6] = (fl[3] ? gp[6] + 1 : gp[6] - 1) & 32'h0000_0FFF;
        rdc(8'h06, gp[6]);
        rdc(8'h03, gp[3]);
        chk_reg(32'(data_addr_o), gp[4 + retire_i.dp_sel]);
        // Call saves state, later changes are undone by the return.
        t = mk(OP_NONE);
        t.call = 1'b1;
        t.next_pc = 11'h040;
        u_exec.issue(t);
        wr(8'h00, 32'h0000_BEEF);
        wr(8'h01, 32'h0000_CAFE);
        wr(8'h04, 32'h0000_0ABC);
        u_exec.issue(mk(fl[3] ? OP_STEP_DN : OP_STEP_UP));
        t = mk(OP_NONE);
        t.ret = 1'b1;
        t.next_pc = 11'h300;
        u_exec.issue(t);
        rdc(8'h00, gp[0]);
        rdc(8'h01, gp[1]);
        rdc(8'h04, gp[4]);
        rdc(IDX_FLAGS, fl);
        chk_reg(32'(pc_o), 32'h0000_0040);
        // Stop with its interrupt enabled, then launch again.
        wr(IDX_HCTRL, 32'h0000_0010);
        u_exec.issue(mk(OP_STOP));
        @(negedge clk_i);
        chk_pin(run_o, 1'b0);
        rdc(IDX_HSTAT, 32'h0000_0010);
        chk_pin(irq_o, 1'b1);
        u_exec.issue(mk(fl[0] ? OP_CLR_CARRY : OP_SET_CARRY));
        rdc(IDX_FLAGS, fl);
        v = go_n;
        wr(IDX_HCTRL, 32'h0000_0018);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk_reg(go_n - v, 32'h0000_0001);
        chk_pin(run_o, 1'b1);
        rdc(IDX_HCTRL, 32'h0000_0010);
        wr(IDX_HSTAT, 32'h0000_0001);
        rdc(IDX_HSTAT, 32'h0000_0000);
        chk_pin(irq_o, 1'b0);
        // Notify keeps running and obeys only its own enable.
        u_exec.issue(mk(OP_NOTIFY));
        @(negedge clk_i);
        chk_pin(irq_o, 1'b0);
        chk_pin(run_o, 1'b1);
        rdc(IDX_HSTAT, 32'h0000_0020);
        wr(IDX_HCTRL, 32'h0000_0020);
        @(negedge clk_i);
        chk_pin(irq_o, 1'b1);
        wr(IDX_HSTAT, 32'h0000_0002);
        rdc(IDX_HSTAT, 32'h0000_0000);
        chk_pin(irq_o, 1'b0);
        // Counter force clears a pending stop and loads the preset.
        u_exec.issue(mk(OP_STOP));
        wr(IDX_HCTRL, 32'h0000_0012);
        rdc(IDX_HSTAT, 32'h0000_0000);
        chk_reg(32'(pc_o), 32'h0000_05A3);
        wr(IDX_HCTRL, 32'h0000_0010);
        @(negedge clk_i);
        chk_pin(run_o, 1'b1);
        // Soft reset wipes core state and pending flags.
        wr(8'h00, 32'h0000_5A5A);
        u_exec.issue(mk(OP_NOTIFY));
        wr(IDX_HCTRL, 32'h0000_0001);
        rdc(8'h00, 32'h0000_0000);
        rdc(IDX_HSTAT, 32'h0000_0000);
        rdc(IDX_FLAGS, 32'h0000_0018);
        chk_pin(core_rst_o, 1'b1);
        chk_reg(32'(pc_o), 32'h0000_05A3);
        give_verdict();
    end
endmodule : tb_scr_core_regs
